// *** erpi_pkg.sv ***
// Package of constants and types for the external RAM port interface.
package erpi_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned INSTR_NS = 250;
  localparam int unsigned ACCESS_MIN_NS = 1000;
  localparam int unsigned ACCESS_MAX_NS = 2000;
  localparam int unsigned INSTR_CYC_I = (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC_I = (ACCESS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 8;
  localparam logic [TMR_W-1:0] INSTR_CYC = TMR_W'(INSTR_CYC_I);
  localparam logic [TMR_W-1:0] ACCESS_CYC = TMR_W'(ACCESS_CYC_I);
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  typedef enum logic [1:0] {
    ERPI_IDLE = 2'b00,
    ERPI_ADDR = 2'b01,
    ERPI_STROBE = 2'b11,
    ERPI_HOLD = 2'b10
  } erpi_state_t;
endpackage

// *** erpi_tmr_if.sv ***
// Interface between the sequencer and its instruction-cycle timer.
`timescale 1ns/1ps
interface erpi_tmr_if;
  logic start;
  logic [erpi_pkg::TMR_W-1:0] len;
  logic done;
  modport ctrl (output start, output len, input done);
  modport tmr (input start, input len, output done);
endinterface

// *** erpi_timer.sv ***
// Down-counting timer that paces each step of a memory sequence.
`timescale 1ns/1ps
module erpi_timer (
  input wire logic clk,
  input wire logic rst_n,
  erpi_tmr_if.tmr t
);
  import erpi_pkg::*;
  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] next_cnt;
  wire cnt_live = (cnt != TMR_W'(0));
  assign next_cnt = t.start ? t.len : (cnt_live ? cnt - TMR_W'(1) : cnt);
  assign t.done = (cnt == TMR_W'(1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt <= '0;
    else cnt <= next_cnt;
  end
endmodule

// *** erpi_top.sv ***
// Sequencer that drives an external byte-wide RAM through address, data and control ports.
`timescale 1ns/1ps
module erpi_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [erpi_pkg::ADDR_W-1:0] req_addr,
  input wire logic [erpi_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [erpi_pkg::DATA_W-1:0] rsp_rdata,
  output logic [7:0] mem_addr_high_port,
  output logic [7:0] mem_addr_low_port,
  input wire logic [erpi_pkg::DATA_W-1:0] io_vector_port_in,
  output logic [erpi_pkg::DATA_W-1:0] io_vector_port_out,
  output logic io_vector_port_oe,
  output logic mem_rd_n,
  output logic mem_wr_n
);
  import erpi_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // A step ends on the edge at which the timer expires while the sequencer sits in that step.
  function automatic logic step_over(
    input erpi_state_t cur,
    input erpi_state_t at,
    input logic done
  );
    step_over = (cur == at) && done;
  endfunction

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  // Reset takes hold at once but leaves on a clock edge, so no flop sees a release near its edge.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // Data port synchroniser
  // ----------------------------------------
  // The RAM drives the data port asynchronously, so it is retimed before use.
  logic [DATA_W-1:0] din_meta;
  logic [DATA_W-1:0] din_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      din_meta <= DATA_RST;
      din_sync <= DATA_RST;
    end else begin
      din_meta <= io_vector_port_in;
      din_sync <= din_meta;
    end
  end

  // ----------------------------------------
  // Step timer
  // ----------------------------------------
  // One shared counter paces the address, strobe and hold steps, so no two steps can overlap.
  erpi_tmr_if tif ();
  erpi_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .t(tif)
  );

  // ----------------------------------------
  // Sequencer decode
  // ----------------------------------------
  // Requests are looked at only in the idle step; a busy sequencer ignores them.
  erpi_state_t state;
  erpi_state_t next_state;
  logic op_write;
  wire take = (state == ERPI_IDLE) && req_valid;
  wire step = tif.done;
  wire addr_end = step_over(state, ERPI_ADDR, step);
  wire strobe_end = step_over(state, ERPI_STROBE, step);
  wire hold_end = step_over(state, ERPI_HOLD, step);
  wire read_cycle = !op_write;

  assign req_ready = (state == ERPI_IDLE);
  assign tif.start = take | addr_end | strobe_end;
  assign tif.len = addr_end ? ACCESS_CYC : INSTR_CYC;

  always_comb begin
    next_state = state;
    unique case (state)
      ERPI_IDLE: begin
        if (take) next_state = ERPI_ADDR;
      end
      ERPI_ADDR: begin
        if (step) next_state = ERPI_STROBE;
      end
      ERPI_STROBE: begin
        if (step) next_state = ERPI_HOLD;
      end
      ERPI_HOLD: begin
        if (step) next_state = ERPI_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Address and data next values
  // ----------------------------------------
  // The address is held after the access so a following cycle can reuse it.
  logic [7:0] next_mem_addr_high_port;
  logic [7:0] next_mem_addr_low_port;
  logic next_op_write;
  logic [DATA_W-1:0] next_io_vector_port_out;
  logic next_io_vector_port_oe;

  assign next_mem_addr_high_port = take ? req_addr[ADDR_W-1:8] : mem_addr_high_port;
  assign next_mem_addr_low_port = take ? req_addr[7:0] : mem_addr_low_port;
  assign next_op_write = take ? req_write : op_write;
  assign next_io_vector_port_out = take ? req_wdata : io_vector_port_out;
  // Data stays driven through the hold step so the write ends with stable data.
  assign next_io_vector_port_oe = take ? req_write : (hold_end ? 1'b0 : io_vector_port_oe);

  // ----------------------------------------
  // Control and response next values
  // ----------------------------------------
  // Both strobes come from one decode, so they are never low together.
  logic next_mem_rd_n;
  logic next_mem_wr_n;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic next_rsp_valid;

  assign next_mem_rd_n = addr_end ? op_write : (strobe_end ? 1'b1 : mem_rd_n);
  assign next_mem_wr_n = addr_end ? !op_write : (strobe_end ? 1'b1 : mem_wr_n);
  // Read data must reach the pin two clocks before the strobe ends to pass the retiming.
  assign next_rsp_rdata = (strobe_end && read_cycle) ? din_sync : rsp_rdata;
  // One response per access; pacing sets the isolated and looped byte rates.
  assign next_rsp_valid = hold_end;

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // The sequencer leaves reset idle, so the first request is taken at once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= ERPI_IDLE;
    else state <= next_state;
  end

  // ----------------------------------------
  // Address and data registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_high_port <= ADDR_RST;
      mem_addr_low_port <= ADDR_RST;
    end else begin
      mem_addr_high_port <= next_mem_addr_high_port;
      mem_addr_low_port <= next_mem_addr_low_port;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_write <= 1'b0;
      io_vector_port_out <= DATA_RST;
    end else begin
      op_write <= next_op_write;
      io_vector_port_out <= next_io_vector_port_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) io_vector_port_oe <= 1'b0;
    else io_vector_port_oe <= next_io_vector_port_oe;
  end

  // ----------------------------------------
  // Control and response registers
  // ----------------------------------------
  // Strobes leave reset inactive, so the RAM sees no access while reset settles.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd_n <= 1'b1;
      mem_wr_n <= 1'b1;
    end else begin
      mem_rd_n <= next_mem_rd_n;
      mem_wr_n <= next_mem_wr_n;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rsp_rdata <= DATA_RST;
    else rsp_rdata <= next_rsp_rdata;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rsp_valid <= 1'b0;
    else rsp_valid <= next_rsp_valid;
  end
endmodule

// *** erpi_ram_model.sv ***
// Behavioural byte-wide RAM on the far side of the port sequencer.
`timescale 1ns/1ps
module erpi_ram_model (
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] wdata,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [7:0] q
);
  int dly_ns = 40;
  logic [7:0] mem [0:65535];
  initial q = 8'h96;
  // Released lines flip, so stale read data never passes for valid data.
  always @(rd_n) begin
    if (rd_n) q <= ~q;
    else q <= #(dly_ns) mem[{addr_hi, addr_lo}];
  end
  always @(posedge wr_n) mem[{addr_hi, addr_lo}] <= wdata;
endmodule

// *** erpi_top_properties.sv ***
// Timing checks on the external RAM port sequencer.
`timescale 1ns/1ps
module erpi_top_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [15:0] req_addr,
  input wire logic rsp_valid,
  input wire logic [7:0] mem_addr_high_port,
  input wire logic [7:0] mem_addr_low_port,
  input wire logic io_vector_port_oe,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n
);
  wire take = req_valid && req_ready;
  wire idle = mem_rd_n && mem_wr_n;
  wire [15:0] addr = {mem_addr_high_port, mem_addr_low_port};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rsp; take |-> ##40 rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("late rsp");
  property p_busy; take |-> ##39 !req_ready ##1 req_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready");
  property p_go; take |-> ##7 idle ##1 !idle; endproperty
  a_go: assert property (p_go) else $error("strobe start");
  property p_rd; $fell(mem_rd_n) |-> ##24 !mem_rd_n ##1 mem_rd_n; endproperty
  a_rd: assert property (p_rd) else $error("read length");
  property p_wr; $fell(mem_wr_n) |-> ##24 !mem_wr_n ##1 mem_wr_n; endproperty
  a_wr: assert property (p_wr) else $error("write length");
  property p_addr; take |=> addr == $past(req_addr); endproperty
  a_addr: assert property (p_addr) else $error("address");
  property p_hold; !idle |-> $stable(addr); endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_oe; !idle |-> io_vector_port_oe == !mem_wr_n; endproperty
  a_oe: assert property (p_oe) else $error("data drive");
endmodule
bind erpi_top erpi_top_properties i_props (.*);

// *** tb_ext_ram_port_interface.sv ***
// Self-checking bench for the external RAM port sequencer.
`timescale 1ns/1ps
module tb_ext_ram_port_interface;
  logic clk = 0, rstn = 0, req_valid = 0, req_write = 0;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_wdata = 8'h00, ram_q, rdata, hi, lo, out;
  logic req_ready, rsp_valid, oe, rd_n, wr_n;
  int err_total = 0, checks_done = 0, cyc = 0;
  localparam int XFER_CYC = 2 * erpi_pkg::INSTR_CYC_I + erpi_pkg::ACCESS_CYC_I;
  logic [24:0] rows [6] = '{25'h10000A5, 25'h1FFFF3C, 25'h1FF007E, 25'h00000A5, 25'h0FFFF3C, 25'h0FF007E};
  wire [7:0] port_in = oe ? out : ram_q;
  erpi_top i_dut (.clk, .rstn, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid,
    .rsp_rdata(rdata), .mem_addr_high_port(hi), .mem_addr_low_port(lo), .io_vector_port_in(port_in),
    .io_vector_port_out(out), .io_vector_port_oe(oe), .mem_rd_n(rd_n), .mem_wr_n(wr_n));
  erpi_ram_model i_ram (.addr_hi(hi), .addr_lo(lo), .wdata(out), .rd_n, .wr_n, .q(ram_q));
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic xfer(input logic [24:0] r);
    int n = 0;
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'h1, r};
    while (req_ready !== 1'h1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, req_ready}, 16'h0001);
    n = 0;
    @(negedge clk);
    req_valid = 0;
    while (rsp_valid !== 1'h1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'(XFER_CYC));
    if (!r[24]) chk({8'h00, rdata}, {8'h00, r[7:0]});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    @(negedge clk);
    chk({rd_n, wr_n, oe, rsp_valid, req_ready}, 16'h0019);
    repeat (4) @(negedge clk);
    rstn = 1;
    repeat (3) @(negedge clk);
    // Slow part after the six table rows, so a late answer cannot leak into the earlier rows.
    foreach (rows[i]) xfer(rows[i]);
    i_ram.dly_ns = 800;
    xfer(rows[5]);
    // Reset in mid-write must drop the strobe at once and leave the sequencer idle.
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'h1, 25'h1123455};
    @(negedge clk);
    req_valid = 0;
    repeat (10) @(negedge clk);
    chk({rd_n, wr_n, oe, rsp_valid, req_ready}, 16'h0014);
    rstn = 0;
    @(negedge clk);
    chk({rd_n, wr_n, oe, rsp_valid, req_ready}, 16'h0019);
    chk({hi, lo}, 16'h0000);
    repeat (4) @(negedge clk);
    rstn = 1;
    repeat (3) @(negedge clk);
    xfer(rows[4]);
    give_verdict();
  end
endmodule
